// File: core/port_two_pkg.sv
/*
  package for the three-pin port with serial pin sharing: register offsets,
  field positions, reset values and power mode codes.
  assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
*/
package port_two_pkg;

  // register byte offsets (one aligned word each)
  localparam logic [3:0] data_off      = 4'h0;
  localparam logic [3:0] direction_off = 4'h4;
  localparam logic [3:0] pin_mode_off  = 4'h8;
  localparam logic [3:0] serial_off    = 4'hC;

  // widths
  localparam int pin_count = 3;
  localparam int reg_width = 8;

  // reset values
  localparam logic [7:0] data_reset      = 8'h00;
  localparam logic [7:0] direction_reset = 8'h00;
  localparam logic [7:0] direction_read  = 8'hFF;
  localparam logic [7:0] pin_mode_reset  = 8'hF8;
  localparam logic [7:0] pin_mode_rsvd   = 8'hF8;
  localparam logic [7:0] serial_reset    = 8'h00;

  // field positions
  localparam int tx_pin_select_bit   = 2;
  localparam int rx_enable_pos       = 4;
  localparam int clk_src_hi_pos      = 1;
  localparam int clk_src_lo_pos      = 0;
  localparam int sync_mode_pos       = 2;

  // pin numbers
  localparam int tx_pin  = 2;
  localparam int rx_pin  = 1;
  localparam int clk_pin = 0;

  // power modes
  localparam logic [2:0] mode_active    = 3'h0;
  localparam logic [2:0] mode_subactive = 3'h1;
  localparam logic [2:0] mode_sleep     = 3'h2;
  localparam logic [2:0] mode_subsleep  = 3'h3;
  localparam logic [2:0] mode_watch     = 3'h4;
  localparam logic [2:0] mode_standby   = 3'h5;

endpackage

// File: core/pin_sync.sv
/*
  two-flop synchroniser for a bus of pin inputs.
  assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int width = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // levels
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);

  logic [width-1:0] meta_q;

  // first flop feeds only the second one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: core/pin_hold.sv
/*
  per-pin output driver with hold and float behaviour across power modes.
  assumes mode codes from port_two_pkg and drives enables active low.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_hold #(
  parameter int width = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // power mode
  input  wire logic [2:0]       power_mode,
  // functional drive, active high enable
  input  wire logic [width-1:0] func_out,
  input  wire logic [width-1:0] func_drive,
  // pin side, enable active low
  output logic      [width-1:0] pin_out,
  output logic      [width-1:0] pin_oe_b
);

  logic hold, float_pins;

  // sleep-like modes freeze, standby floats
  assign hold       = (power_mode == port_two_pkg::mode_sleep) ||
                      (power_mode == port_two_pkg::mode_subsleep) ||
                      (power_mode == port_two_pkg::mode_watch);
  assign float_pins = (power_mode == port_two_pkg::mode_standby);

  // reset floats every pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out  <= '0;
      pin_oe_b <= '1;
    end else if (float_pins) begin
      pin_oe_b <= '1;
    end else if (!hold) begin
      pin_out  <= func_out;
      pin_oe_b <= ~func_drive;
    end
  end

endmodule
`default_nettype wire

// File: core/port_two.sv
/*
  three-pin general purpose port with pins shared by the serial unit.
  holds the data, direction, pin mode and serial selection registers.
  assumes an avalon-mm master on clk, asynchronous pins, and a serial unit
  on the same clock that supplies its own drive and takes pin levels.
*/
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - data register bits 2..0 drive pins
// - data bits 7..3 read zero, ignore writes
// - output pin reads latched data
// - input pin reads sampled pin level
// - data register resets to zero
// - direction one is output, zero input
// - port registers act only in gpio use
// - direction register reads all ones
// - direction register resets to zero
// - tx select makes pin 2 transmit
// - clock bits and sync mode pick pin 0 clock role
// - float in reset, standby; hold sleeping
module port_two (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // power mode
  input  wire logic [2:0]  power_mode,
  // serial unit
  input  wire logic        serial_tx_out,
  input  wire logic        serial_clk_out,
  output logic             serial_rx_in,
  output logic             serial_clk_in,
  // pins
  input  wire logic [2:0]  pin_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe_b
);

  logic [2:0]  data_q;
  logic [2:0]  direction_q;
  logic        tx_select_q;
  logic [2:0]  serial_ctl_q;
  logic        sync_mode_q;
  logic [2:0]  pin_level;
  logic        ack_q;
  logic        wr_en;
  logic [31:0] rd_d;
  logic        clk_in_role;
  logic        clk_out_role;
  logic [2:0]  serial_owned;
  logic [2:0]  func_out;
  logic [2:0]  func_drive;
  logic [2:0]  port_read;

  // pins pass two flops before anything looks at them
  pin_sync #(
    .width (3)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  // one wait cycle per access, answer on the second edge;
  // a write lands only at the edge that sees waitrequest low
  assign waitrequest = (read || write) && !ack_q;
  assign wr_en       = write && ack_q && byteenable[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  // data register keeps only the three pin bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= port_two_pkg::data_reset[2:0];
    end else if (wr_en && address == port_two_pkg::data_off) begin
      data_q <= writedata[2:0];
    end
  end

  // direction register, write only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      direction_q <= port_two_pkg::direction_reset[2:0];
    end else if (wr_en && address == port_two_pkg::direction_off) begin
      direction_q <= writedata[2:0];
    end
  end

  // pin mode register: transmit pin select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_select_q <= port_two_pkg::pin_mode_reset[port_two_pkg::tx_pin_select_bit];
    end else if (wr_en && address == port_two_pkg::pin_mode_off) begin
      tx_select_q <= writedata[port_two_pkg::tx_pin_select_bit];
    end
  end

  // serial selection: rx enable, clock source hi/lo, sync mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_ctl_q <= 3'h0;
      sync_mode_q  <= port_two_pkg::serial_reset[port_two_pkg::sync_mode_pos];
    end else if (wr_en && address == port_two_pkg::serial_off) begin
      serial_ctl_q <= {writedata[port_two_pkg::rx_enable_pos],
                       writedata[port_two_pkg::clk_src_hi_pos],
                       writedata[port_two_pkg::clk_src_lo_pos]};
      sync_mode_q  <= writedata[port_two_pkg::sync_mode_pos];
    end
  end

  // pin 0 role: hi bit wins and makes it a clock input
  assign clk_in_role  = serial_ctl_q[1];
  assign clk_out_role = !serial_ctl_q[1] && (serial_ctl_q[0] || sync_mode_q);

  // ownership of each pin
  assign serial_owned = {tx_select_q, serial_ctl_q[2], clk_in_role || clk_out_role};

  // per-pin function mux
  always_comb begin
    func_out   = data_q;
    func_drive = direction_q;
    if (tx_select_q) begin
      func_out[port_two_pkg::tx_pin]   = serial_tx_out;
      func_drive[port_two_pkg::tx_pin] = 1'b1;
    end
    if (serial_ctl_q[2]) begin
      func_drive[port_two_pkg::rx_pin] = 1'b0;
    end
    if (clk_in_role) begin
      func_drive[port_two_pkg::clk_pin] = 1'b0;
    end else if (clk_out_role) begin
      func_out[port_two_pkg::clk_pin]   = serial_clk_out;
      func_drive[port_two_pkg::clk_pin] = 1'b1;
    end
  end

  // inputs routed to the serial unit
  assign serial_rx_in  = pin_level[port_two_pkg::rx_pin];
  assign serial_clk_in = pin_level[port_two_pkg::clk_pin];

  pin_hold #(
    .width (3)
  ) u_hold (
    .clk        (clk),
    .rst_b      (rst_b),
    .power_mode (power_mode),
    .func_out   (func_out),
    .func_drive (func_drive),
    .pin_out    (pin_out),
    .pin_oe_b   (pin_oe_b)
  );

  // read value per pin: latch when output and not serial owned, level otherwise
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_read
      assign port_read[gi] = (direction_q[gi] && !serial_owned[gi]) ? data_q[gi]
                                                                    : pin_level[gi];
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (address)
      port_two_pkg::data_off:      rd_d = {29'h0, port_read};
      port_two_pkg::direction_off: rd_d = {24'h0, port_two_pkg::direction_read};
      port_two_pkg::pin_mode_off:  rd_d = {24'h0, port_two_pkg::pin_mode_rsvd | {5'h0, tx_select_q, 2'h0}};
      port_two_pkg::serial_off:    rd_d = {27'h0, serial_ctl_q[2], 1'b0, sync_mode_q,
                                           serial_ctl_q[1], serial_ctl_q[0]};
      default:                     rd_d = 32'h0000_0000;
    endcase
  end

  // read data registered at the first (wait) edge of a read, ahead of the answering edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata <= rd_d;
    end
  end

endmodule
`default_nettype wire

// File: tb/port_two_props.sv
/* checker for port_two bus, pin and power mode timing.
   assumes it is bound to port_two and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module port_two_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // mode and pins
  input wire logic [2:0]  power_mode,
  input wire logic [2:0]  pin_in,
  input wire logic [2:0]  pin_out,
  input wire logic [2:0]  pin_oe_b,
  input wire logic        serial_rx_in,
  input wire logic        serial_clk_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sleeping modes freeze outputs; read done is the bus sampling edge
  wire logic hold_mode = power_mode inside {3'h2, 3'h3, 3'h4};
  wire logic rd_done   = read && !waitrequest;
  a_float_reset: assert property ($rose(rst_b) |-> pin_oe_b == 3'h7)
    else $error("pins driven at reset exit");
  a_standby_float: assert property (power_mode == 3'h5 [*2] |-> pin_oe_b == 3'h7)
    else $error("pins driven in standby");
  a_sleep_hold: assert property (hold_mode [*2] |=> $stable(pin_out) && $stable(pin_oe_b))
    else $error("pins moved while sleeping");
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait on first cycle");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  a_dir_ones: assert property (rd_done && address == 4'h4 |-> readdata == 32'hFF)
    else $error("direction read not all ones");
  a_data_rsvd: assert property (rd_done && address == 4'h0 |-> readdata[31:3] == 29'h0)
    else $error("data reserved bits set");
  a_unmapped_zero: assert property (rd_done && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_serial_sync: assert property ($past(rst_b, 2) && $past(rst_b) |->
    {serial_rx_in, serial_clk_in} == {$past(pin_in[1], 2), $past(pin_in[0], 2)})
    else $error("serial inputs lag pins wrongly");
endmodule
bind port_two port_two_props u_props (.clk, .rst_b, .address, .read, .write, .readdata, .waitrequest,
  .power_mode, .pin_in, .pin_out, .pin_oe_b, .serial_rx_in, .serial_clk_in);
`default_nettype wire

// File: tb/pin_partner.sv
/* outside world of the three pins.
   assumes pin_oe_b low means the port drives that pin. */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // port side
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_b,
  // outside drivers, never left floating
  input  wire logic [2:0] ext,
  // level seen on the wire
  output logic      [2:0] pin_in
);
  // port wins where it drives, else the outside level
  assign pin_in = (pin_out & ~pin_oe_b) | (ext & pin_oe_b);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* self-checking bench for port_two over avalon-mm.
   assumes pin_partner resolves pins and the bench plays the serial unit. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] dat = port_two_pkg::data_off;
  localparam logic [3:0] dir = port_two_pkg::direction_off;
  localparam logic [3:0] pmd = port_two_pkg::pin_mode_off;
  localparam logic [3:0] ser = port_two_pkg::serial_off;
  logic        clk, rst_b, read, write, waitrequest, serial_tx_out, serial_clk_out, serial_rx_in, serial_clk_in;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [2:0]  power_mode, pin_in, pin_out, pin_oe_b, ext;
  logic [7:0]  cks [4] = '{8'h02, 8'h01, 8'h04, 8'h00};
  logic        cko [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          n_fail, check_count;
  port_two u_dut (.clk, .rst_b, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .power_mode, .serial_tx_out, .serial_clk_out, .serial_rx_in, .serial_clk_in, .pin_in, .pin_out, .pin_oe_b);
  pin_partner u_pins (.pin_out, .pin_oe_b, .ext, .pin_in);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one bus access; holds until waitrequest is seen low at an edge
  task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    address   <= a;
    read      <= !w;
    write     <= w;
    writedata <= {24'h0, d};
    // only the watchdog ends a wait that never finishes
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // floating pins carry no meaning, so only driven values are compared
  task automatic pins(input logic [2:0] oe_b, input logic [2:0] o);
    repeat (3) @(posedge clk);
    chk({29'h0, pin_oe_b}, {29'h0, oe_b});
    chk({29'h0, pin_out & ~pin_oe_b}, {29'h0, o});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #20us;
    n_fail++;
    close_out();
  end
  initial begin
    {rst_b, read, write, serial_tx_out, serial_clk_out, address, writedata, power_mode, ext} = '0;
    byteenable = 4'hF;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    pins(3'h7, 3'h0);
    rd(dat, 8'h00);
    rd(dir, 8'hFF);
    rd(pmd, 8'hF8);
    $display("reset test done");
    acc(dat, 1'b1, 8'hFD);
    acc(dir, 1'b1, 8'hFF);
    pins(3'h0, 3'h5);
    rd(dat, 8'h05);
    ext <= 3'h2;
    acc(dir, 1'b1, 8'h00);
    pins(3'h7, 3'h0);
    rd(dat, 8'h02);
    acc(dir, 1'b1, 8'h05);
    rd(dat, 8'h07);
    power_mode <= port_two_pkg::mode_standby;
    ext        <= 3'h0;
    pins(3'h7, 3'h0);
    rd(dat, 8'h05);
    // wake first, so sleep freezes driven pins rather than floated ones
    power_mode <= port_two_pkg::mode_subactive;
    pins(3'h2, 3'h5);
    power_mode <= port_two_pkg::mode_sleep;
    acc(dat, 1'b1, 8'h00);
    pins(3'h2, 3'h5);
    power_mode <= port_two_pkg::mode_active;
    pins(3'h2, 3'h0);
    power_mode <= port_two_pkg::mode_watch;
    acc(dir, 1'b1, 8'h00);
    pins(3'h2, 3'h0);
    power_mode <= port_two_pkg::mode_subsleep;
    pins(3'h2, 3'h0);
    power_mode <= port_two_pkg::mode_active;
    pins(3'h7, 3'h0);
    byteenable <= 4'h0;
    acc(dat, 1'b1, 8'h07);
    byteenable <= 4'hF;
    rd(dat, 8'h00);
    acc(4'h2, 1'b1, 8'hFF);
    rd(4'h2, 8'h00);
    $display("gpio test done");
    serial_tx_out <= 1'b1;
    acc(dir, 1'b1, 8'h00);
    acc(pmd, 1'b1, 8'h04);
    pins(3'h3, 3'h4);
    serial_tx_out <= 1'b0;
    pins(3'h3, 3'h0);
    acc(pmd, 1'b1, 8'h00);
    acc(dir, 1'b1, 8'h02);
    acc(ser, 1'b1, 8'h10);
    ext <= 3'h2;
    pins(3'h7, 3'h0);
    chk({31'h0, serial_rx_in}, 32'h1);
    acc(dir, 1'b1, 8'h00);
    serial_clk_out <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(ser, 1'b1, cks[i]);
      pins({2'b11, ~cko[i]}, {2'b00, cko[i]});
    end
    $display("serial test done");
    close_out();
  end
endmodule
`default_nettype wire
